// File: core/sbt_pkg.sv
/*
  constants and types of the serial port unit timing core.
  assumes one core clock; counts are in core_clock_period units.
*/
package sbt_pkg;

    localparam int unsigned CORE_HZ_48      = 48_000_000;
    localparam int unsigned CORE_HZ_60      = 60_000_000;
    localparam int unsigned CORE_HZ_80      = 80_000_000;
    localparam int unsigned SCK_PREF_MAX_HZ = 40_000_000;
    localparam int unsigned SLV_MIN_PER_NS  = 50;
    localparam int unsigned DIV_EXP_MAX     = 8;
    localparam int unsigned SETUP_CYC       = 25;
    localparam int unsigned HOLD_CYC        = 880;
    localparam int unsigned GAP_CYC         = 6;
    localparam logic [3:0]  SEL_IDLE        = 4'hf;
    localparam logic [4:0]  EDGES_W1        = 5'h0f;
    localparam logic [4:0]  EDGES_W2        = 5'h07;
    localparam logic [4:0]  EDGES_W4        = 5'h03;

    typedef enum logic [1:0]
    {
        SBT_W1 = 2'b00,
        SBT_W2 = 2'b01,
        SBT_W4 = 2'b10
    } sbt_width_t;

    typedef struct packed
    {
        logic       masterMode;
        logic       clockIdleLevel;
        logic       clockSamplePhase;
        sbt_width_t width;
        logic [3:0] divExp;
        logic [1:0] selectIdx;
    } sbt_cfg_t;

    typedef struct packed
    {
        logic [7:0] data;
        logic       last;
        logic       readOnly;
    } sbt_tx_t;

    typedef enum logic [2:0]
    {
        ST_IDLE  = 3'b000,
        ST_SETUP = 3'b001,
        ST_SHIFT = 3'b010,
        ST_GAP   = 3'b011,
        ST_HOLD  = 3'b100
    } sbt_state_t;

endpackage

// File: core/sbt_core.sv
/*
  serial port unit timing core: master timing and a link-clock slave.
  assumes static cfg in transfers; board joins slvMisoOut and misoOut.
*/
`timescale 1ns/10ps
module sbt_core #(
    parameter int unsigned SETUP_CYC = sbt_pkg::SETUP_CYC,
    parameter int unsigned HOLD_CYC  = sbt_pkg::HOLD_CYC,
    parameter int unsigned GAP_CYC   = sbt_pkg::GAP_CYC
)(
    // clock and reset
    input  wire logic              ref_clk,
    input  wire logic              rst_b,
    // configuration
    input  wire sbt_pkg::sbt_cfg_t cfg,
    // transmit stream
    input  wire logic              txValid,
    output logic                   txReady,
    input  wire sbt_pkg::sbt_tx_t  txWord,
    // receive stream
    output logic                   rxValid,
    input  wire logic              rxReady,
    output logic [7:0]             rxData,
    output logic                   busy,
    // serial clock
    output logic                   sclkOut,
    output logic                   sclkOe,
    input  wire logic              slvSclk,
    input  wire logic              slvSelectN,
    // data pins
    input  wire logic              mosiIn,
    output logic                   mosiOut,
    output logic                   mosiOe,
    input  wire logic              misoIn,
    output logic                   misoOut,
    output logic                   misoOe,
    input  wire logic              quadDataBit2In,
    output logic                   quadDataBit2Out,
    output logic                   quadDataBit2Oe,
    input  wire logic              quadDataBit3In,
    output logic                   quadDataBit3Out,
    output logic                   quadDataBit3Oe,
    output logic                   slvMisoOut,
    output logic                   slvMisoOe,
    // slave selects
    output logic [3:0]             selectOutN
);

    localparam int unsigned CW = 10;

    sbt_pkg::sbt_state_t state_q;
    logic [CW-1:0]       cnt_q;
    logic [7:0]          halfCnt_q;
    logic [4:0]          edgeCnt_q;
    logic [7:0]          txSh_q;
    logic [7:0]          rxSh_q;
    logic [3:0]          outBits_q;
    logic [3:0]          dataOe_q;
    logic [3:0]          selectOutN_q;
    logic                sclk_q;
    logic                sclkOe_q;
    logic                last_q;
    logic                readOnly_q;
    logic                txReady_q;
    logic                busy_q;
    logic [4:0]          pinMeta_q;
    logic [4:0]          pinSync_q;
    logic [7:0]          rxHead_q;
    logic [7:0]          rxSpare_q;
    logic                rxValid_q;
    logic                spareValid_q;
    logic [7:0]          slvHold_q;
    logic                slvHoldFull_q;
    logic                slvMisoOe_q;
    logic [2:0]          tglPipe_q;
    // link clock domain
    logic [2:0]          slvBit_q;
    logic [6:0]          slvRxSh_q;
    logic [7:0]          slvRxByte_q;
    logic                slvDoneTgl_q;
    logic [2:0]          slvLaunch_q;
    logic [7:0]          slvTxSh_q;
    logic                slvMiso_q;

    logic [3:0]          expC;
    logic [8:0]          halfLast9;
    logic [7:0]          halfLast;
    logic [4:0]          edgeLast;
    logic                tick;
    logic                byteDone;
    logic                sampleNow;
    logic                launchNow;
    logic                take;
    logic                masterTake;
    logic                canTake;
    logic                slvEvent;
    logic                push;
    logic [7:0]          pushData;
    logic                slvEdgeClk;
    logic                slvRst_b;

    function automatic logic [3:0] chunkOf(logic [7:0] d,
                                           sbt_pkg::sbt_width_t w);
        unique case (w)
            sbt_pkg::SBT_W2: chunkOf = {2'h0, d[7], d[6]};
            sbt_pkg::SBT_W4: chunkOf = d[7:4];
            default:         chunkOf = {3'h0, d[7]};
        endcase
    endfunction

    function automatic logic [7:0] shiftOf(logic [7:0] d,
                                           sbt_pkg::sbt_width_t w);
        unique case (w)
            sbt_pkg::SBT_W2: shiftOf = {d[5:0], 2'h0};
            sbt_pkg::SBT_W4: shiftOf = {d[3:0], 4'h0};
            default:         shiftOf = {d[6:0], 1'h0};
        endcase
    endfunction

    function automatic logic [7:0] sampleIn(logic [7:0] s, logic [3:0] i,
                                            sbt_pkg::sbt_width_t w);
        unique case (w)
            sbt_pkg::SBT_W2: sampleIn = {s[5:0], i[1:0]};
            sbt_pkg::SBT_W4: sampleIn = {s[3:0], i};
            default:         sampleIn = {s[6:0], i[1]};
        endcase
    endfunction

    // 2**n core periods per phase, n clamped to 8
    assign expC      = (cfg.divExp > 4'h8) ? 4'h8 : cfg.divExp;
    assign halfLast9 = (9'h001 << expC) - 9'h001;
    assign halfLast  = halfLast9[7:0];
    assign edgeLast  = (cfg.width == sbt_pkg::SBT_W4) ? sbt_pkg::EDGES_W4 :
                       (cfg.width == sbt_pkg::SBT_W2) ? sbt_pkg::EDGES_W2 :
                       sbt_pkg::EDGES_W1;
    assign tick      = (state_q == sbt_pkg::ST_SHIFT) &&
                       (halfCnt_q == halfLast);
    assign byteDone  = tick && (edgeCnt_q == edgeLast);
    // even edge index is a leading edge; phase picks sample or launch
    assign sampleNow = ~edgeCnt_q[0] ^ cfg.clockSamplePhase;
    assign launchNow = ~sampleNow && (edgeCnt_q != edgeLast);
    assign take       = txValid && txReady_q;
    assign masterTake = take && cfg.masterMode;
    assign slvEvent   = tglPipe_q[1] ^ tglPipe_q[2];

    always_comb
    begin
        canTake = 1'b0;
        if (cfg.masterMode)
        begin
            canTake = !spareValid_q &&
                      ((state_q == sbt_pkg::ST_IDLE) ||
                       ((state_q == sbt_pkg::ST_GAP) &&
                        (cnt_q == CW'(GAP_CYC - 1))));
        end
        else
        begin
            canTake = !slvHoldFull_q;
        end
    end

    always_comb
    begin
        push     = 1'b0;
        pushData = rxSh_q;
        if (cfg.masterMode)
        begin
            push     = byteDone;
            pushData = cfg.clockSamplePhase ?
                       sampleIn(rxSh_q, pinSync_q[3:0], cfg.width) : rxSh_q;
        end
        else
        begin
            push     = slvEvent;
            pushData = slvRxByte_q;
        end
    end

    // pin inputs pass two flops; wide read-back needs n of 2 or more
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pinMeta_q <= 5'h1f;
            pinSync_q <= 5'h1f;
        end
        else
        begin
            pinMeta_q <= {slvSelectN, quadDataBit3In, quadDataBit2In,
                          misoIn, mosiIn};
            pinSync_q <= pinMeta_q;
        end
    end

    // master sequencer, all on the one core clock
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_q      <= sbt_pkg::ST_IDLE;
            cnt_q        <= '0;
            halfCnt_q    <= 8'h00;
            edgeCnt_q    <= 5'h00;
            selectOutN_q <= sbt_pkg::SEL_IDLE;
            busy_q       <= 1'b0;
        end
        else
        begin
            unique case (state_q)
                sbt_pkg::ST_IDLE:
                begin
                    if (masterTake)
                    begin
                        state_q      <= sbt_pkg::ST_SETUP;
                        cnt_q        <= '0;
                        busy_q       <= 1'b1;
                        // one-hot low decode keeps a single select
                        selectOutN_q <= ~(4'h1 << cfg.selectIdx);
                    end
                end
                sbt_pkg::ST_SETUP:
                begin
                    if (cnt_q == CW'(SETUP_CYC - 1))
                    begin
                        state_q   <= sbt_pkg::ST_SHIFT;
                        halfCnt_q <= 8'h00;
                        edgeCnt_q <= 5'h00;
                    end
                    else
                    begin
                        cnt_q <= cnt_q + CW'(1);
                    end
                end
                sbt_pkg::ST_SHIFT:
                begin
                    if (tick)
                    begin
                        halfCnt_q <= 8'h00;
                        if (edgeCnt_q == edgeLast)
                        begin
                            state_q <= last_q ? sbt_pkg::ST_HOLD :
                                                sbt_pkg::ST_GAP;
                            cnt_q   <= '0;
                        end
                        else
                        begin
                            edgeCnt_q <= edgeCnt_q + 5'h01;
                        end
                    end
                    else
                    begin
                        halfCnt_q <= halfCnt_q + 8'h01;
                    end
                end
                sbt_pkg::ST_GAP:
                begin
                    // gap stretches while the source or the sink stalls
                    if (masterTake)
                    begin
                        state_q   <= sbt_pkg::ST_SHIFT;
                        halfCnt_q <= 8'h00;
                        edgeCnt_q <= 5'h00;
                    end
                    else if (cnt_q != CW'(GAP_CYC - 1))
                    begin
                        cnt_q <= cnt_q + CW'(1);
                    end
                end
                sbt_pkg::ST_HOLD:
                begin
                    if (cnt_q == CW'(HOLD_CYC - 1))
                    begin
                        state_q      <= sbt_pkg::ST_IDLE;
                        selectOutN_q <= sbt_pkg::SEL_IDLE;
                        busy_q       <= 1'b0;
                    end
                    else
                    begin
                        cnt_q <= cnt_q + CW'(1);
                    end
                end
                default:
                begin
                    state_q      <= sbt_pkg::ST_IDLE;
                    selectOutN_q <= sbt_pkg::SEL_IDLE;
                    busy_q       <= 1'b0;
                end
            endcase
        end
    end

    // one toggle per phase, so period is high plus low
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sclk_q   <= 1'b0;
            sclkOe_q <= 1'b0;
        end
        else
        begin
            sclkOe_q <= cfg.masterMode;
            if (tick)
            begin
                sclk_q <= ~sclk_q;
            end
            else if (state_q == sbt_pkg::ST_IDLE)
            begin
                sclk_q <= cfg.clockIdleLevel;
            end
        end
    end

    // master shift datapath
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            txSh_q     <= 8'h00;
            rxSh_q     <= 8'h00;
            outBits_q  <= 4'h0;
            last_q     <= 1'b0;
            readOnly_q <= 1'b0;
        end
        else if (masterTake)
        begin
            last_q     <= txWord.last;
            readOnly_q <= txWord.readOnly;
            if (cfg.clockSamplePhase)
            begin
                txSh_q <= txWord.data;
            end
            else
            begin
                // phase 0 puts the first bit out before the first edge
                txSh_q    <= shiftOf(txWord.data, cfg.width);
                outBits_q <= chunkOf(txWord.data, cfg.width);
            end
        end
        else if (tick)
        begin
            if (sampleNow)
            begin
                rxSh_q <= sampleIn(rxSh_q, pinSync_q[3:0], cfg.width);
            end
            if (launchNow)
            begin
                outBits_q <= chunkOf(txSh_q, cfg.width);
                txSh_q    <= shiftOf(txSh_q, cfg.width);
            end
        end
    end

    // pin enables; wide widths only as master
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            dataOe_q    <= 4'h0;
            slvMisoOe_q <= 1'b0;
        end
        else
        begin
            slvMisoOe_q <= !cfg.masterMode && !pinSync_q[4];
            if (!cfg.masterMode)
            begin
                dataOe_q <= 4'h0;
            end
            else if (cfg.width == sbt_pkg::SBT_W1)
            begin
                dataOe_q <= 4'h1;
            end
            else if (readOnly_q)
            begin
                dataOe_q <= 4'h0;
            end
            else
            begin
                dataOe_q <= (cfg.width == sbt_pkg::SBT_W4) ? 4'hf : 4'h3;
            end
        end
    end

    // transmit handshake and slave hold word
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            txReady_q     <= 1'b0;
            slvHold_q     <= 8'h00;
            slvHoldFull_q <= 1'b0;
            tglPipe_q     <= 3'h0;
        end
        else
        begin
            txReady_q <= canTake && !take;
            tglPipe_q <= {tglPipe_q[1:0], slvDoneTgl_q};
            // a load beats a consume in the same cycle
            if (take && !cfg.masterMode)
            begin
                slvHold_q     <= txWord.data;
                slvHoldFull_q <= 1'b1;
            end
            else if (slvEvent)
            begin
                slvHoldFull_q <= 1'b0;
            end
        end
    end

    // two-entry receive buffer; a stalled slave byte is dropped
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rxHead_q     <= 8'h00;
            rxSpare_q    <= 8'h00;
            rxValid_q    <= 1'b0;
            spareValid_q <= 1'b0;
        end
        else if (rxValid_q && rxReady)
        begin
            if (spareValid_q)
            begin
                rxHead_q     <= rxSpare_q;
                rxSpare_q    <= pushData;
                spareValid_q <= push;
            end
            else
            begin
                rxHead_q  <= pushData;
                rxValid_q <= push;
            end
        end
        else if (push && !rxValid_q)
        begin
            rxHead_q  <= pushData;
            rxValid_q <= 1'b1;
        end
        else if (push && !spareValid_q)
        begin
            rxSpare_q    <= pushData;
            spareValid_q <= 1'b1;
        end
    end

    // link domain: samples on the rising edge of this clock
    assign slvEdgeClk = slvSclk ^
                        (cfg.clockIdleLevel ^ cfg.clockSamplePhase);
    assign slvRst_b   = rst_b & ~slvSelectN;

    always_ff @(posedge slvEdgeClk or negedge slvRst_b)
    begin
        if (!slvRst_b)
        begin
            slvBit_q  <= 3'h0;
            slvRxSh_q <= 7'h00;
        end
        else
        begin
            slvBit_q  <= slvBit_q + 3'h1;
            slvRxSh_q <= {slvRxSh_q[5:0], mosiIn};
        end
    end

    always_ff @(posedge slvEdgeClk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            slvRxByte_q  <= 8'h00;
            slvDoneTgl_q <= 1'b0;
        end
        else if (slvBit_q == 3'h7)
        begin
            slvRxByte_q  <= {slvRxSh_q, mosiIn};
            slvDoneTgl_q <= ~slvDoneTgl_q;
        end
    end

    always_ff @(negedge slvEdgeClk or negedge slvRst_b)
    begin
        if (!slvRst_b)
        begin
            slvLaunch_q <= 3'h0;
        end
        else
        begin
            slvLaunch_q <= slvLaunch_q + 3'h1;
        end
    end

    // next byte is taken from the hold word without a gap
    always_ff @(negedge slvEdgeClk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            slvTxSh_q <= 8'h00;
            slvMiso_q <= 1'b0;
        end
        else if (slvLaunch_q == (cfg.clockSamplePhase ? 3'h0 : 3'h7))
        begin
            slvMiso_q <= slvHold_q[7];
            slvTxSh_q <= {slvHold_q[6:0], 1'b0};
        end
        else
        begin
            slvMiso_q <= slvTxSh_q[7];
            slvTxSh_q <= {slvTxSh_q[6:0], 1'b0};
        end
    end

    assign txReady         = txReady_q;
    assign rxValid         = rxValid_q;
    assign rxData          = rxHead_q;
    assign busy            = busy_q;
    assign sclkOut         = sclk_q;
    assign sclkOe          = sclkOe_q;
    assign mosiOut         = outBits_q[0];
    assign mosiOe          = dataOe_q[0];
    assign misoOut         = outBits_q[1];
    assign misoOe          = dataOe_q[1];
    assign quadDataBit2Out = outBits_q[2];
    assign quadDataBit2Oe  = dataOe_q[2];
    assign quadDataBit3Out = outBits_q[3];
    assign quadDataBit3Oe  = dataOe_q[3];
    assign slvMisoOut      = slvMiso_q;
    assign slvMisoOe       = slvMisoOe_q;
    assign selectOutN      = selectOutN_q;

endmodule

// File: test/sbt_core_assertions.sv
/* port assertions for the timing core.
   assumes static cfg. */
`timescale 1ns/10ps
module sbt_core_assertions #(
    parameter int unsigned SETUP_CYC = 25,
    parameter int unsigned HOLD_CYC  = 880,
    parameter int unsigned GAP_CYC   = 6
)(
    // watched ports
    input wire logic              ref_clk,
    input wire logic              rst_b,
    input wire sbt_pkg::sbt_cfg_t cfg,
    input wire logic              busy,
    input wire logic              sclkOut,
    input wire logic              mosiOut,
    input wire logic              mosiOe,
    input wire logic              misoOe,
    input wire logic              quadDataBit2Oe,
    input wire logic              quadDataBit3Oe,
    input wire logic [3:0]        selectOutN
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    logic        sclkP_q;
    logic        seen_q;
    logic [15:0] quiet_q;
    logic [15:0] low_q;
    wire  [15:0] half = 16'h1 << cfg.divExp;
    // quiet_q: cycles since a clock toggle, low_q: since select low
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sclkP_q <= 1'b0;
            seen_q  <= 1'b0;
            quiet_q <= 16'h0;
            low_q   <= 16'h0;
        end
        else
        begin
            sclkP_q <= sclkOut;
            seen_q  <= selectOutN != 4'hf && (seen_q || sclkOut != sclkP_q);
            quiet_q <= (sclkOut != sclkP_q) ? 16'h0 : quiet_q + 16'h1;
            low_q   <= (selectOutN == 4'hf) ? 16'h0 : low_q + 16'h1;
        end
    end
    property p_selIdx;
        selectOutN != 4'hf |-> selectOutN == ~(4'h1 << cfg.selectIdx);
    endproperty
    a_selIdx: assert property (p_selIdx) else $error("wrong select");
    property p_busySel;
        !busy |-> selectOutN == 4'hf;
    endproperty
    a_busySel: assert property (p_busySel) else $error("select low");
    property p_idle;
        $past(rst_b) && cfg.masterMode && !busy && $stable(cfg)
            |-> sclkOut == cfg.clockIdleLevel;
    endproperty
    a_idle: assert property (p_idle) else $error("clock not idle");
    property p_setup;
        $changed(sclkOut) && !seen_q && selectOutN != 4'hf
            |-> low_q >= SETUP_CYC;
    endproperty
    a_setup: assert property (p_setup) else $error("short setup");
    property p_hold;
        $rose(selectOutN == 4'hf) |-> quiet_q >= HOLD_CYC - 1;
    endproperty
    a_hold: assert property (p_hold) else $error("short hold");
    property p_phase;
        busy && $changed(sclkOut)
            |-> quiet_q == half - 1 || quiet_q >= GAP_CYC + half - 1;
    endproperty
    a_phase: assert property (p_phase) else $error("bad phase");
    property p_launch;
        busy && $changed(sclkOut)
            && (sclkOut ^ cfg.clockIdleLevel ^ cfg.clockSamplePhase)
            |-> $stable(mosiOut);
    endproperty
    a_launch: assert property (p_launch) else $error("data moved");
    property p_slvPins;
        !cfg.masterMode && !$past(cfg.masterMode)
            |-> !(mosiOe || misoOe || quadDataBit2Oe || quadDataBit3Oe);
    endproperty
    a_slvPins: assert property (p_slvPins) else $error("slave drives");
endmodule
bind sbt_core sbt_core_assertions #(
    .SETUP_CYC(SETUP_CYC), .HOLD_CYC(HOLD_CYC), .GAP_CYC(GAP_CYC)
) chk (.ref_clk, .rst_b, .cfg, .busy, .sclkOut, .mosiOut, .mosiOe,
    .misoOe, .quadDataBit2Oe, .quadDataBit3Oe, .selectOutN);

// File: test/sbt_slave_model.sv
/* behavioural slave behind the master link.
   assumes the bench resolves every data pin. */
`timescale 1ns/10ps
module sbt_slave_model #(
    parameter logic [15:0] TX = 16'h3cc5
)(
    // link
    input wire logic       sclk,
    input wire logic       selN,
    input wire logic       clock_idle_level,
    input wire logic       clock_sample_phase,
    input wire logic       w4,
    input wire logic [3:0] din,
    // answer
    output logic           sdo,
    output logic [15:0]    rx
);
    logic [16:0] sh = 17'h0;
    // rising s samples in all four formats
    wire         s = sclk ^ clock_idle_level ^ clock_sample_phase;
    always @(negedge selN)
        sh <= clock_sample_phase ? {1'b0, TX} : {TX, 1'b0};
    always @(posedge s)
        if (!selN)
            rx <= w4 ? {rx[11:0], din} : {rx[14:0], din[0]};
    always @(negedge s)
        if (!selN)
            sh <= sh << 1;
    // released line shows the inverse of its last bit
    assign sdo = selN ? ~sh[16] : sh[16];
endmodule

// File: test/tb_sbt_core.sv
/* bench: master transfers into a slave model, then a slave transfer.
   assumes the package and checker are compiled first. */
`timescale 1ns/10ps
module tb_sbt_core;
    localparam int unsigned HOLD = 20;
    logic              ref_clk    = 1'b0;
    logic              rst_b      = 1'b0;
    // master, idle high
    sbt_pkg::sbt_cfg_t cfg        = 11'h600;
    sbt_pkg::sbt_tx_t  txWord     = '0;
    logic              txValid    = 1'b0;
    logic              rxReady    = 1'b0;
    logic              slvSclk    = 1'b0;
    logic              slvSelectN = 1'b1;
    logic              sMosi      = 1'b0;
    logic              txReady, rxValid, busy, sclkOut, sdo;
    logic              mosiOut, mosiOe, misoOut, misoOe, smOut, smOe;
    logic              q2Out, q2Oe, q3Out, q3Oe;
    logic [7:0]        rxData;
    logic [3:0]        selectOutN;
    logic [15:0]       got;
    int                miscompares = 0;
    int                compares    = 0;
    wire               mosi = mosiOe ? mosiOut : sMosi;
    wire               miso = misoOe ? misoOut : smOe ? smOut : sdo;
    wire               q2   = q2Oe ? q2Out : ~q2Out;
    wire               q3   = q3Oe ? q3Out : ~q3Out;
    always #20 ref_clk = ~ref_clk;
    sbt_core #(.HOLD_CYC(HOLD)) uut (
        .ref_clk, .rst_b, .cfg, .txValid, .txReady, .txWord, .rxValid,
        .rxReady, .rxData, .busy, .sclkOut, .sclkOe(), .slvSclk,
        .slvSelectN, .mosiIn(mosi), .mosiOut, .mosiOe, .misoIn(miso),
        .misoOut, .misoOe, .quadDataBit2In(q2), .quadDataBit2Out(q2Out),
        .quadDataBit2Oe(q2Oe), .quadDataBit3In(q3),
        .quadDataBit3Out(q3Out), .quadDataBit3Oe(q3Oe),
        .slvMisoOut(smOut), .slvMisoOe(smOe), .selectOutN);
    sbt_slave_model peer (.sclk(sclkOut), .selN(selectOutN[cfg.selectIdx]),
        .clock_idle_level(cfg.clockIdleLevel), .clock_sample_phase(cfg.clockSamplePhase),
        .w4(cfg.width == sbt_pkg::SBT_W4), .din({q3, q2, miso, mosi}),
        .sdo, .rx(got));
    task automatic results();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        compares++;
        if (g !== e)
        begin
            miscompares++;
            $display("unexpected at %0t: got %h exp %h", $time, g, e);
        end
    endtask
    // tasks start and end just after a rising edge
    task automatic put(input logic [7:0] d, input logic l);
        txWord <= '{data: d, last: l, readOnly: 1'b0};
        txValid <= 1'b1;
        @(posedge ref_clk);
        while (txReady !== 1'b1)
            @(posedge ref_clk);
    endtask
    task automatic pop(input logic [7:0] e);
        while (rxValid !== 1'b1)
            @(posedge ref_clk);
        chk({8'h0, rxData}, {8'h0, e});
        rxReady <= 1'b1;
        @(posedge ref_clk);
        rxReady <= 1'b0;
        @(posedge ref_clk);
    endtask
    // two bytes, rx stalled: both wait in the buffer
    task automatic master(input logic [1:0] m, input sbt_pkg::sbt_width_t w,
                          input logic [3:0] n);
        cfg <= '{masterMode: 1'b1, clockIdleLevel: m[1],
                 clockSamplePhase: m[0], width: w, divExp: n, selectIdx: m};
        repeat (3) @(posedge ref_clk);
        chk({15'h0, sclkOut}, {15'h0, m[1]});
        put(8'ha6, 1'b0);
        put(8'h5b, 1'b1);
        txValid <= 1'b0;
        while (busy !== 1'b0)
            @(posedge ref_clk);
        chk({12'h0, selectOutN}, 16'h000f);
        chk(got, 16'ha65b);
        if (w == sbt_pkg::SBT_W1)
        begin
            pop(8'h3c);
            pop(8'hc5);
        end
        rxReady <= 1'b1;
        repeat (3) @(posedge ref_clk);
        rxReady <= 1'b0;
    endtask
    // continuous 80 ns link clock, no gap between bytes
    task automatic slave();
        cfg <= '0;
        repeat (4) @(posedge ref_clk);
        #13 slvSelectN = 1'b0;
        for (int i = 15; i >= 0; i--)
        begin
            sMosi = 16'h9e71 >> i;
            #40 slvSclk = 1'b1;
            #40 slvSclk = 1'b0;
        end
        chk({15'h0, smOe}, 16'h0001);
        #40 slvSelectN = 1'b1;
        @(posedge ref_clk);
        pop(8'h9e);
        pop(8'h71);
    endtask
    initial
    begin
        repeat (5) @(posedge ref_clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge ref_clk);
        chk({12'h0, selectOutN}, 16'h000f);
        chk({15'h0, sclkOut}, 16'h0001);
        master(2'd0, sbt_pkg::SBT_W4, 4'h0);
        for (int m = 0; m < 4; m++)
            master(2'(m), sbt_pkg::SBT_W1, 4'h2);
        slave();
        results();
    end
    initial
    begin
        #400_000;
        miscompares++;
        results();
    end
endmodule
